//--- pkg/msr_cfg.svh
// offsets, field positions, reset values and codes of the soft-iron and axis-remap bank
// Operation
// - coefficients are half floats: sign, 5 exponent, 10 fraction
// - low byte at lower address, high byte next
// - one off-diagonal coefficient serves both mirrored positions
// - m22 and m33 reset to one (0x3c00)
// - off-diagonal coefficient bytes reset to zero
// - Y selector code map, others +Y, reset 000
// - Z selector same map, reset 101
// - X selector same map, reset 010
// - X sel bits 2:0; Y 6:4, Z 2:0
// - coefficient registers read back last written value
// - m11 resets to one (0x3c00)
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH

`define MSR_IDX_M11_LOW 8'hc6
`define MSR_IDX_M11_HIGH 8'hc7
`define MSR_IDX_M12_LOW 8'hc8
`define MSR_IDX_M12_HIGH 8'hc9
`define MSR_IDX_M13_LOW 8'hca
`define MSR_IDX_M13_HIGH 8'hcb
`define MSR_IDX_M22_LOW 8'hcc
`define MSR_IDX_M22_HIGH 8'hcd
`define MSR_IDX_M23_LOW 8'hce
`define MSR_IDX_M23_HIGH 8'hcf
`define MSR_IDX_M33_LOW 8'hd0
`define MSR_IDX_M33_HIGH 8'hd1
`define MSR_IDX_REMAP_YZ 8'hd4
`define MSR_IDX_REMAP_X 8'hd5
`define MSR_IDX_STATUS 8'hd6
`define MSR_IDX_COUNT_LOW 8'hd7
`define MSR_IDX_COUNT_HIGH 8'hd8

`define MSR_NUM_COEF 6
`define MSR_NUM_COEF_BYTES 12
`define MSR_BYTE_M11_HIGH 1
`define MSR_BYTE_M22_HIGH 7
`define MSR_BYTE_M33_HIGH 11
`define MSR_COEF_M11 0
`define MSR_COEF_M12 1
`define MSR_COEF_M13 2
`define MSR_COEF_M22 3
`define MSR_COEF_M23 4
`define MSR_COEF_M33 5

`define MSR_RST_BYTE 8'h00
`define MSR_RST_DIAG_HIGH 8'h3c
`define MSR_RST_Y_SEL 3'h0
`define MSR_RST_Z_SEL 3'h5
`define MSR_RST_X_SEL 3'h2

`define MSR_Y_SEL_LSB 4
`define MSR_Z_SEL_LSB 0
`define MSR_X_SEL_LSB 0
`define MSR_SEL_W 3

`define MSR_HALF_SIGN 15
`define MSR_HALF_EXP_MSB 14
`define MSR_HALF_EXP_LSB 10
`define MSR_HALF_FRAC_MSB 9

`define MSR_SEL_POS_Y 3'h0
`define MSR_SEL_NEG_Y 3'h1
`define MSR_SEL_POS_X 3'h2
`define MSR_SEL_NEG_X 3'h3
`define MSR_SEL_NEG_Z 3'h4
`define MSR_SEL_POS_Z 3'h5

`endif

//--- pkg/msr_pkg.sv
// types of the soft-iron and axis-remap bank
package msr_pkg;
  typedef logic [15:0] msr_half_t;
  typedef logic [2:0] msr_sel_t;

  typedef struct packed {
    logic [11:0][7:0] coef_byte;
    msr_sel_t x_sel;
    msr_sel_t y_sel;
    msr_sel_t z_sel;
    logic [31:0] prdata;
    logic pslverr;
    logic out_valid;
    msr_half_t out_x;
    msr_half_t out_y;
    msr_half_t out_z;
    logic [5:0][15:0] applied;
    logic [15:0] sample_cnt;
  } msr_state_s;
endpackage : msr_pkg

//--- pkg/msr_coef_if.sv
// one coefficient and its decoded half-float fields
`timescale 1ns/1ps
interface msr_coef_if;
  import msr_pkg::*;
  msr_half_t value;
  logic sign;
  logic [4:0] exponent;
  logic [9:0] fraction;
  logic is_zero;
  logic non_finite;
  modport dec (input value, output sign, exponent, fraction, is_zero, non_finite);
  modport use_side (output value, input sign, exponent, fraction, is_zero, non_finite);
endinterface : msr_coef_if

//--- hw/msr_half_dec.sv
// splits a half-precision coefficient into its fields
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_half_dec
  import msr_pkg::*;
(
  msr_coef_if.dec coef
);
  always_comb begin
    coef.sign = coef.value[`MSR_HALF_SIGN];
    coef.exponent = coef.value[`MSR_HALF_EXP_MSB:`MSR_HALF_EXP_LSB];
    coef.fraction = coef.value[`MSR_HALF_FRAC_MSB:0];
    coef.is_zero = (coef.value[`MSR_HALF_EXP_MSB:0] == 15'h0000);
    // all-ones exponent means inf or nan; flagged, not corrected
    coef.non_finite = &coef.value[`MSR_HALF_EXP_MSB:`MSR_HALF_EXP_LSB];
  end
endmodule : msr_half_dec

//--- hw/msr_axis_sel.sv
// picks one remapped axis from the raw half-float sample
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_axis_sel
  import msr_pkg::*;
(
  input wire msr_sel_t sel,
  input wire msr_half_t raw_x,
  input wire msr_half_t raw_y,
  input wire msr_half_t raw_z,
  output msr_half_t axis
);
  // negation of a half float is a sign flip, exact for every value
  always_comb begin
    case (sel)
      `MSR_SEL_POS_Y: axis = raw_y;
      `MSR_SEL_NEG_Y: axis = {~raw_y[`MSR_HALF_SIGN], raw_y[`MSR_HALF_EXP_MSB:0]};
      `MSR_SEL_POS_X: axis = raw_x;
      `MSR_SEL_NEG_X: axis = {~raw_x[`MSR_HALF_SIGN], raw_x[`MSR_HALF_EXP_MSB:0]};
      `MSR_SEL_NEG_Z: axis = {~raw_z[`MSR_HALF_SIGN], raw_z[`MSR_HALF_EXP_MSB:0]};
      `MSR_SEL_POS_Z: axis = raw_z;
      default: axis = raw_y;
    endcase
  end
endmodule : msr_axis_sel

//--- hw/msr_top.sv
// soft-iron matrix and axis-remap register bank on apb, with sample path
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_top
  import msr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MAG_IN_VALID,
  input wire logic [15:0] MAG_IN_X,
  input wire logic [15:0] MAG_IN_Y,
  input wire logic [15:0] MAG_IN_Z,
  output logic MAG_OUT_VALID,
  output logic [15:0] MAG_OUT_X,
  output logic [15:0] MAG_OUT_Y,
  output logic [15:0] MAG_OUT_Z,
  output logic [15:0] COEF_R1C1,
  output logic [15:0] COEF_R1C2,
  output logic [15:0] COEF_R1C3,
  output logic [15:0] COEF_R2C1,
  output logic [15:0] COEF_R2C2,
  output logic [15:0] COEF_R2C3,
  output logic [15:0] COEF_R3C1,
  output logic [15:0] COEF_R3C2,
  output logic [15:0] COEF_R3C3,
  output logic COEF_FAULT
);
  msr_state_s s;
  msr_state_s next_s;

  logic apb_setup;
  logic apb_write;
  logic [7:0] reg_idx;
  logic addr_ok;
  logic [7:0] coef_pos;
  logic coef_hit;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [5:0] non_finite;
  logic [5:0] is_zero;
  msr_half_t remapped [3];
  msr_sel_t sel_of [3];

  msr_coef_if cif [6] ();

  // live fields of the applied coefficients, used by the status register
  generate
    for (genvar c = 0; c < `MSR_NUM_COEF; c++) begin : g_dec
      assign cif[c].value = s.applied[c];
      assign non_finite[c] = cif[c].non_finite;
      assign is_zero[c] = cif[c].is_zero;
      msr_half_dec u_dec (
        .coef(cif[c])
      );
    end
  endgenerate

  assign sel_of[0] = s.x_sel;
  assign sel_of[1] = s.y_sel;
  assign sel_of[2] = s.z_sel;

  generate
    for (genvar a = 0; a < 3; a++) begin : g_axis
      msr_axis_sel u_sel (
        .sel(sel_of[a]),
        .raw_x(MAG_IN_X),
        .raw_y(MAG_IN_Y),
        .raw_z(MAG_IN_Z),
        .axis(remapped[a])
      );
    end
  endgenerate

  // printed offsets are word indices; byte address is four times the index
  assign reg_idx = PADDR[9:2];
  assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0);
  assign coef_pos = reg_idx - `MSR_IDX_M11_LOW;
  assign coef_hit = addr_ok && (reg_idx >= `MSR_IDX_M11_LOW) && (reg_idx <= `MSR_IDX_M33_HIGH);
  assign apb_setup = PSEL && !PENABLE;
  // zero wait states: every access phase completes in its first cycle
  assign apb_write = PSEL && PENABLE && PWRITE && PSTRB[0] && !s.pslverr;

  // read decode; reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (coef_hit) begin
      rd_byte = s.coef_byte[coef_pos[3:0]];
    end else if (addr_ok && reg_idx == `MSR_IDX_REMAP_YZ) begin
      rd_byte[`MSR_Y_SEL_LSB +: `MSR_SEL_W] = s.y_sel;
      rd_byte[`MSR_Z_SEL_LSB +: `MSR_SEL_W] = s.z_sel;
    end else if (addr_ok && reg_idx == `MSR_IDX_REMAP_X) begin
      rd_byte[`MSR_X_SEL_LSB +: `MSR_SEL_W] = s.x_sel;
    end else if (addr_ok && reg_idx == `MSR_IDX_STATUS) begin
      rd_byte = {2'h0, non_finite};
    end else if (addr_ok && reg_idx == `MSR_IDX_COUNT_LOW) begin
      rd_byte = s.sample_cnt[7:0];
    end else if (addr_ok && reg_idx == `MSR_IDX_COUNT_HIGH) begin
      rd_byte = s.sample_cnt[15:8];
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    next_s = s;
    next_s.out_valid = 1'b0;
    // decode is captured in setup and held; the master keeps the address stable
    if (apb_setup) begin
      next_s.prdata = {24'h000000, rd_byte};
      next_s.pslverr = !rd_hit || (PWRITE && !coef_hit
        && !(addr_ok && reg_idx == `MSR_IDX_REMAP_YZ)
        && !(addr_ok && reg_idx == `MSR_IDX_REMAP_X));
    end
    if (apb_write) begin
      if (coef_hit) begin
        next_s.coef_byte[coef_pos[3:0]] = PWDATA[7:0];
      end else if (reg_idx == `MSR_IDX_REMAP_YZ) begin
        // reserved bits 7 and 3 are not stored, so they read back zero
        next_s.y_sel = PWDATA[`MSR_Y_SEL_LSB +: `MSR_SEL_W];
        next_s.z_sel = PWDATA[`MSR_Z_SEL_LSB +: `MSR_SEL_W];
      end else begin
        next_s.x_sel = PWDATA[`MSR_X_SEL_LSB +: `MSR_SEL_W];
      end
    end
    // a write in the same cycle as a sample lands one sample later
    if (MAG_IN_VALID) begin
      next_s.out_valid = 1'b1;
      next_s.out_x = remapped[0];
      next_s.out_y = remapped[1];
      next_s.out_z = remapped[2];
      next_s.sample_cnt = s.sample_cnt + 16'h0001;
      for (int c = 0; c < `MSR_NUM_COEF; c++) begin
        next_s.applied[c] = {s.coef_byte[2 * c + 1], s.coef_byte[2 * c]};
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      s <= '0;
      s.coef_byte[`MSR_BYTE_M11_HIGH] <= `MSR_RST_DIAG_HIGH;
      s.coef_byte[`MSR_BYTE_M22_HIGH] <= `MSR_RST_DIAG_HIGH;
      s.coef_byte[`MSR_BYTE_M33_HIGH] <= `MSR_RST_DIAG_HIGH;
      s.applied[`MSR_COEF_M11] <= {`MSR_RST_DIAG_HIGH, `MSR_RST_BYTE};
      s.applied[`MSR_COEF_M22] <= {`MSR_RST_DIAG_HIGH, `MSR_RST_BYTE};
      s.applied[`MSR_COEF_M33] <= {`MSR_RST_DIAG_HIGH, `MSR_RST_BYTE};
      s.x_sel <= `MSR_RST_X_SEL;
      s.y_sel <= `MSR_RST_Y_SEL;
      s.z_sel <= `MSR_RST_Z_SEL;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && s.pslverr;
  assign MAG_OUT_VALID = s.out_valid;
  assign MAG_OUT_X = s.out_x;
  assign MAG_OUT_Y = s.out_y;
  assign MAG_OUT_Z = s.out_z;
  // mirrored positions share one stored coefficient
  assign COEF_R1C1 = s.applied[`MSR_COEF_M11];
  assign COEF_R1C2 = s.applied[`MSR_COEF_M12];
  assign COEF_R2C1 = s.applied[`MSR_COEF_M12];
  assign COEF_R1C3 = s.applied[`MSR_COEF_M13];
  assign COEF_R3C1 = s.applied[`MSR_COEF_M13];
  assign COEF_R2C2 = s.applied[`MSR_COEF_M22];
  assign COEF_R2C3 = s.applied[`MSR_COEF_M23];
  assign COEF_R3C2 = s.applied[`MSR_COEF_M23];
  assign COEF_R3C3 = s.applied[`MSR_COEF_M33];
  // a zero diagonal collapses an axis; flagged together with inf and nan
  assign COEF_FAULT = |non_finite || is_zero[`MSR_COEF_M11] || is_zero[`MSR_COEF_M22]
    || is_zero[`MSR_COEF_M33];
endmodule : msr_top

//--- dv/msr_top_monitor.sv
// port assertions of the soft-iron and axis-remap bank
`timescale 1ns/1ps
module msr_top_monitor (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MAG_IN_VALID,
  input wire logic MAG_OUT_VALID,
  input wire logic [15:0] MAG_OUT_X,
  input wire logic [15:0] COEF_R1C2,
  input wire logic [15:0] COEF_R2C1,
  input wire logic [15:0] COEF_R1C3,
  input wire logic [15:0] COEF_R3C1,
  input wire logic [15:0] COEF_R2C2,
  input wire logic [15:0] COEF_R2C3,
  input wire logic [15:0] COEF_R3C2
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("error outside access");
  a_rd_upper: assert property (PRDATA[31:8] == 24'h0) else $error("read data upper bits set");
  a_out_latency: assert property (MAG_IN_VALID |=> MAG_OUT_VALID)
    else $error("output valid missing");
  a_out_cause: assert property (MAG_OUT_VALID |-> $past(MAG_IN_VALID))
    else $error("output valid without sample");
  a_hold_out: assert property (!MAG_IN_VALID |=> $stable(MAG_OUT_X))
    else $error("output moved without sample");
  a_hold_coef: assert property (!MAG_IN_VALID |=> $stable(COEF_R2C2))
    else $error("coefficient moved without sample");
  a_sym_12: assert property (COEF_R1C2 == COEF_R2C1) else $error("r1c2 r2c1 differ");
  a_sym_13: assert property (COEF_R1C3 == COEF_R3C1) else $error("r1c3 r3c1 differ");
  a_sym_23: assert property (COEF_R2C3 == COEF_R3C2) else $error("r2c3 r3c2 differ");
endmodule : msr_top_monitor
bind msr_top msr_top_monitor mon_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MAG_IN_VALID(MAG_IN_VALID), .MAG_OUT_VALID(MAG_OUT_VALID), .MAG_OUT_X(MAG_OUT_X),
  .COEF_R1C2(COEF_R1C2), .COEF_R2C1(COEF_R2C1), .COEF_R1C3(COEF_R1C3), .COEF_R3C1(COEF_R3C1),
  .COEF_R2C2(COEF_R2C2), .COEF_R2C3(COEF_R2C3), .COEF_R3C2(COEF_R3C2));

//--- dv/msr_top_test.sv
// self-checking bench of the soft-iron and axis-remap bank
`timescale 1ns/1ps
`include "msr_cfg.svh"
module msr_top_test
  import msr_pkg::*;
;
  logic CLK_SYS = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MAG_IN_VALID = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [3:0] PSTRB = 4'hf;
  msr_half_t MAG_IN_X = '0, MAG_IN_Y = '0, MAG_IN_Z = '0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, MAG_OUT_VALID, COEF_FAULT;
  logic [15:0] MAG_OUT_X, MAG_OUT_Y, MAG_OUT_Z, COEF_R1C1, COEF_R1C2, COEF_R1C3;
  logic [15:0] COEF_R2C1, COEF_R2C2, COEF_R2C3, COEF_R3C1, COEF_R3C2, COEF_R3C3;
  logic [7:0] mb [12];
  logic [2:0] sx, sy, sz;
  int bad_count = 0, comparisons = 0;
  int nsmp = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  msr_top dut_u (.CLK_SYS, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .MAG_IN_VALID, .MAG_IN_X, .MAG_IN_Y, .MAG_IN_Z,
    .MAG_OUT_VALID, .MAG_OUT_X, .MAG_OUT_Y, .MAG_OUT_Z, .COEF_R1C1, .COEF_R1C2, .COEF_R1C3,
    .COEF_R2C1, .COEF_R2C2, .COEF_R2C3, .COEF_R3C1, .COEF_R3C2, .COEF_R3C3, .COEF_FAULT);
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
      output logic [31:0] rd, output logic err);
    @(posedge CLK_SYS);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= wr;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= {24'h0, wd};
    @(posedge CLK_SYS);
    PENABLE <= 1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    apb(1, idx, wd, d, e);
    chk(e, 0);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic e;
    apb(0, idx, 8'h00, d, e);
    chk({e, d}, {1'b0, 24'h0, exp});
  endtask : rdc
  function automatic logic [15:0] cf(int i);
    return {mb[2 * i + 1], mb[2 * i]};
  endfunction : cf
  // all-ones exponent marks inf or nan, one flag per stored coefficient
  function automatic logic [5:0] nfm();
    logic [5:0] f;
    logic [15:0] v;
    for (int i = 0; i < 6; i++) begin
      v = cf(i);
      f[i] = (v[14:10] == 5'h1f);
    end
    return f;
  endfunction : nfm
  // a signed zero on the diagonal collapses an axis, so it is a fault too
  function automatic logic fm();
    logic [15:0] a, b, c;
    a = cf(0);
    b = cf(3);
    c = cf(5);
    return (|nfm()) || a[14:0] == 15'h0 || b[14:0] == 15'h0 || c[14:0] == 15'h0;
  endfunction : fm
  // negation touches the sign bit only, the half-float magnitude is kept
  function automatic logic [15:0] rm(logic [2:0] s);
    case (s)
      3'h1: return MAG_IN_Y ^ 16'h8000;
      3'h2: return MAG_IN_X;
      3'h3: return MAG_IN_X ^ 16'h8000;
      3'h4: return MAG_IN_Z ^ 16'h8000;
      3'h5: return MAG_IN_Z;
      default: return MAG_IN_Y;
    endcase
  endfunction : rm
  task automatic mreset;
    foreach (mb[k]) mb[k] = 8'h00;
    mb[1] = 8'h3c;
    mb[7] = 8'h3c;
    mb[11] = 8'h3c;
    sx = 3'h2;
    sy = 3'h0;
    sz = 3'h5;
    nsmp = 0;
  endtask : mreset
  task automatic smp;
    @(posedge CLK_SYS);
    MAG_IN_VALID <= 1;
    MAG_IN_X <= 16'($urandom);
    MAG_IN_Y <= 16'($urandom);
    MAG_IN_Z <= 16'($urandom);
    @(posedge CLK_SYS);
    MAG_IN_VALID <= 0;
    nsmp++;
    #1;
    chk(MAG_OUT_VALID, 1);
    chk({MAG_OUT_X, MAG_OUT_Y, MAG_OUT_Z}, {rm(sx), rm(sy), rm(sz)});
    chk({COEF_R1C1, COEF_R1C2, COEF_R1C3}, {cf(0), cf(1), cf(2)});
    chk({COEF_R2C1, COEF_R2C2, COEF_R2C3}, {cf(1), cf(3), cf(4)});
    chk({COEF_R3C1, COEF_R3C2, COEF_R3C3}, {cf(2), cf(4), cf(5)});
    chk(COEF_FAULT, fm());
    rdc(`MSR_IDX_STATUS, {2'h0, nfm()});
    rdc(`MSR_IDX_COUNT_LOW, nsmp[7:0]);
    rdc(`MSR_IDX_COUNT_HIGH, nsmp[15:8]);
  endtask : smp
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    logic [31:0] d;
    logic e;
    void'($urandom(32'ha51b8210));
    mreset();
    repeat (2) @(posedge CLK_SYS);
    RESET <= 0;
    for (int k = 0; k < 12; k++) rdc(8'(`MSR_IDX_M11_LOW + k), mb[k]);
    rdc(`MSR_IDX_REMAP_YZ, 8'h05);
    rdc(`MSR_IDX_REMAP_X, 8'h02);
    smp();
    for (int k = 0; k < 12; k++) begin
      mb[k] = 8'($urandom);
      wr(8'(`MSR_IDX_M11_LOW + k), mb[k]);
    end
    // force one non-finite coefficient so the status flag is seen set
    mb[5] = 8'h7c;
    wr(`MSR_IDX_M13_HIGH, mb[5]);
    for (int k = 0; k < 12; k++) rdc(8'(`MSR_IDX_M11_LOW + k), mb[k]);
    #1;
    // applied copy only moves on a sample, not on the write
    chk(COEF_R2C2, 16'h3c00);
    smp();
    for (int c = 0; c < 8; c++) begin
      sy = 3'(c);
      sz = 3'(7 - c);
      sx = 3'(c);
      wr(`MSR_IDX_REMAP_YZ, {1'b0, sy, 1'b0, sz});
      wr(`MSR_IDX_REMAP_X, {5'h0, sx});
      rdc(`MSR_IDX_REMAP_YZ, {1'b0, sy, 1'b0, sz});
      rdc(`MSR_IDX_REMAP_X, {5'h0, sx});
      smp();
    end
    // a negative-zero diagonal raises the fault on its own
    mb[0] = 8'h00;
    mb[1] = 8'h80;
    mb[5] = 8'h00;
    wr(`MSR_IDX_M11_LOW, mb[0]);
    wr(`MSR_IDX_M11_HIGH, mb[1]);
    wr(`MSR_IDX_M13_HIGH, mb[5]);
    // byte lane 0 off: the write completes without error and changes nothing
    PSTRB <= 4'he;
    wr(`MSR_IDX_M22_LOW, ~mb[6]);
    PSTRB <= 4'hf;
    smp();
    // d2 sits in the hole between the matrix and the remap pair
    apb(0, 8'hd2, 8'h00, d, e);
    chk(e, 1);
    apb(1, 8'hd2, 8'h55, d, e);
    chk(e, 1);
    // status is read-only, a write is refused
    apb(1, `MSR_IDX_STATUS, 8'h3f, d, e);
    chk(e, 1);
    rdc(`MSR_IDX_STATUS, {2'h0, nfm()});
    @(posedge CLK_SYS);
    RESET <= 1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 0;
    mreset();
    rdc(`MSR_IDX_M33_HIGH, 8'h3c);
    rdc(`MSR_IDX_M23_LOW, 8'h00);
    smp();
    end_of_test();
  end
endmodule : msr_top_test
